// *** hdl/adc_format_consts.svh ***
`ifndef ADC_FORMAT_CONSTS_SVH
`define ADC_FORMAT_CONSTS_SVH

// ==========================================================================
// Register addresses
`define ADDR_OUTPUT_DRIVER   8'h04
`define ADDR_SAMPLE_FORMAT   8'h05

// ==========================================================================
// Output driver register fields
`define DRV_MODE_BIT         0
`define DRV_DISABLE_BIT      2
`define DRV_TERM_BIT         3
`define DRV_CURRENT_LSB      4
`define DRV_CURRENT_MSB      6
`define DRV_WRITE_MASK       8'h7d
`define OUTPUT_DRIVER_RESET  8'h00

// ==========================================================================
// Sample format register fields
`define FMT_CODING_BIT       0
`define FMT_RANDOMIZER_EN_BIT         1
`define FMT_ABP_BIT          2
`define FMT_TEST_LSB         3
`define FMT_TEST_MSB         5
`define FMT_WRITE_MASK       8'h3f
`define SAMPLE_FORMAT_RESET  8'h00

// ==========================================================================
// Driver current in tenths of a milliampere
`define CUR_TENTHS_4P0       8'h28
`define CUR_TENTHS_4P5       8'h2d
`define CUR_TENTHS_3P0       8'h1e
`define CUR_TENTHS_2P5       8'h19
`define CUR_TENTHS_2P1       8'h15

// ==========================================================================
// Test words, over-range bit above the sixteen data bits
`define PAT_CHECKER          17'h15555
`define PAT_ALL_ONES         17'h1ffff
`define PAT_ALL_ZEROS        17'h00000
`define ODD_BIT_MASK         16'haaaa

`endif

// *** hdl/adc_format_pkg.sv ***
package adc_format_pkg;

    // ======================================================================
    // Encodings held in the registers
    typedef enum logic [2:0]
    {
        TP_OFF      = 3'b000,
        TP_ZEROS    = 3'b001,
        TP_ONES     = 3'b011,
        TP_CHECKER  = 3'b101,
        TP_TOGGLE   = 3'b111
    } test_pattern_type;

    typedef enum logic [2:0]
    {
        DRV_CODE0   = 3'b000,
        DRV_4P0     = 3'b001,
        DRV_4P5     = 3'b010,
        DRV_UNUSED  = 3'b011,
        DRV_3P0     = 3'b100,
        DRV_2P5     = 3'b101,
        DRV_2P1     = 3'b110,
        DRV_CODE7   = 3'b111
    } drive_code_type;

    typedef enum logic
    {
        SIG_DDR_DIFF  = 1'b0,
        SIG_CMOS_FULL = 1'b1
    } signalling_type;

endpackage : adc_format_pkg

// *** hdl/sample_formatter.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "adc_format_consts.svh"

module sample_formatter
#(
    parameter int DATA_WIDTH = 16
)
(
    input  wire logic [DATA_WIDTH-1:0]             sample_in,
    input  wire logic                              over_range_in,
    input  wire adc_format_pkg::test_pattern_type  test_pattern_sel,
    input  wire logic                              signed_coding_sel,
    input  wire logic                              randomizer_en,
    input  wire logic                              alt_polarity_en,
    input  wire logic                              pattern_phase,
    output logic      [DATA_WIDTH-1:0]             word_out,
    output logic                                   over_range_out
);

    logic [DATA_WIDTH-1:0] coded;
    logic [DATA_WIDTH-1:0] scrambled;
    logic [DATA_WIDTH:0]   pattern;
    logic                  use_pattern;

    // ======================================================================
    // Data path
    always_comb
    begin
        coded = sample_in;
        if (signed_coding_sel)
        begin
            coded[DATA_WIDTH-1] = ~sample_in[DATA_WIDTH-1];
        end
        scrambled = coded;
        if (randomizer_en)
        begin
            scrambled[DATA_WIDTH-1:1] = coded[DATA_WIDTH-1:1]
                                      ^ {(DATA_WIDTH-1){coded[0]}};
        end
        if (alt_polarity_en)
        begin
            scrambled = scrambled ^ `ODD_BIT_MASK;
        end
    end

    // ======================================================================
    // Test words
    always_comb
    begin
        use_pattern = 1'b1;
        pattern     = `PAT_ALL_ZEROS;
        unique case (test_pattern_sel)
            adc_format_pkg::TP_ZEROS:   pattern = `PAT_ALL_ZEROS;
            adc_format_pkg::TP_ONES:    pattern = `PAT_ALL_ONES;
            adc_format_pkg::TP_CHECKER:
                pattern = pattern_phase ? ~`PAT_CHECKER : `PAT_CHECKER;
            adc_format_pkg::TP_TOGGLE:
                pattern = pattern_phase ? `PAT_ALL_ONES : `PAT_ALL_ZEROS;
            // Unused codes fall back to live data rather than garbage
            default:                    use_pattern = 1'b0;
        endcase
    end

    always_comb
    begin
        if (use_pattern)
        begin
            word_out       = pattern[DATA_WIDTH-1:0];
            over_range_out = pattern[DATA_WIDTH];
        end
        else
        begin
            word_out       = scrambled;
            over_range_out = over_range_in;
        end
    end

endmodule : sample_formatter
`default_nettype wire

// *** hdl/adc_output_format_control.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "adc_format_consts.svh"

module adc_output_format_control
#(
    parameter int         DATA_WIDTH          = 16,
    parameter logic [7:0] CODE0_CURRENT_TENTHS = 8'h00
)
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  ce,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    output logic                       reg_rd_valid,
    input  wire logic [DATA_WIDTH-1:0] sample_in,
    input  wire logic                  over_range_in,
    input  wire logic                  sample_valid,
    output logic      [DATA_WIDTH-1:0] data_out,
    output logic                       over_range_bit,
    output logic                       out_valid,
    output logic                       data_oe_n,
    output logic                       cmos_mode,
    output logic                       internal_term_en,
    output logic      [2:0]            drive_current_sel,
    output logic      [7:0]            drive_current_tenths,
    output logic                       drive_code_unused
);

    // ======================================================================
    // Register storage
    logic [7:0] output_driver_config;
    logic [7:0] sample_format_config;

    logic                              pattern_phase;
    logic [DATA_WIDTH-1:0]             next_data;
    logic                              next_over_range;
    logic [7:0]                        next_current;
    adc_format_pkg::test_pattern_type  test_pattern_sel;
    adc_format_pkg::signalling_type    signalling;

    // ======================================================================
    // Decoding helpers, each called once
    function automatic logic [7:0] read_value(input logic [7:0] addr,
                                              input logic [7:0] drv,
                                              input logic [7:0] fmt);
        logic [7:0] value;
        value = 8'h00;
        if (addr == `ADDR_OUTPUT_DRIVER)
        begin
            value = drv & `DRV_WRITE_MASK;
        end
        else if (addr == `ADDR_SAMPLE_FORMAT)
        begin
            value = fmt & `FMT_WRITE_MASK;
        end
        return value;
    endfunction : read_value

    function automatic logic [7:0] base_current(input logic [2:0] code,
                                                input logic [7:0] code0);
        logic [7:0] tenths;
        tenths = 8'h00;
        unique case (adc_format_pkg::drive_code_type'(code))
            adc_format_pkg::DRV_CODE0:  tenths = code0;
            adc_format_pkg::DRV_4P0:    tenths = `CUR_TENTHS_4P0;
            adc_format_pkg::DRV_4P5:    tenths = `CUR_TENTHS_4P5;
            adc_format_pkg::DRV_3P0:    tenths = `CUR_TENTHS_3P0;
            adc_format_pkg::DRV_2P5:    tenths = `CUR_TENTHS_2P5;
            adc_format_pkg::DRV_2P1:    tenths = `CUR_TENTHS_2P1;
            adc_format_pkg::DRV_UNUSED: tenths = 8'h00;
            adc_format_pkg::DRV_CODE7:  tenths = 8'h00;
        endcase
        return tenths;
    endfunction : base_current

    // ======================================================================
    // Register writes
    // Unused bits are never stored, so they cannot leak into the read path
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            output_driver_config <= `OUTPUT_DRIVER_RESET;
        end
        else if (ce && reg_wr && reg_addr == `ADDR_OUTPUT_DRIVER)
        begin
            output_driver_config <= reg_wdata & `DRV_WRITE_MASK;
        end
    end

    // Host keeps legal codes
    // Unused test codes are stored as written; the data path passes
    // live samples for them instead of inventing a pattern.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sample_format_config <= `SAMPLE_FORMAT_RESET;
        end
        else if (ce && reg_wr && reg_addr == `ADDR_SAMPLE_FORMAT)
        begin
            sample_format_config <= reg_wdata & `FMT_WRITE_MASK;
        end
    end

    // ======================================================================
    // Register reads
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            reg_rdata    <= 8'h00;
            reg_rd_valid <= 1'b0;
        end
        else if (ce)
        begin
            reg_rd_valid <= reg_rd;
            if (reg_rd)
            begin
                reg_rdata <= read_value(reg_addr, output_driver_config,
                                        sample_format_config);
            end
        end
    end

    // ======================================================================
    // Output stage configuration
    assign test_pattern_sel = adc_format_pkg::test_pattern_type'(
        sample_format_config[`FMT_TEST_MSB:`FMT_TEST_LSB]);
    assign signalling = adc_format_pkg::signalling_type'(
        output_driver_config[`DRV_MODE_BIT]);

    always_comb
    begin
        next_current = base_current(
            output_driver_config[`DRV_CURRENT_MSB:`DRV_CURRENT_LSB],
            CODE0_CURRENT_TENTHS);
        if (output_driver_config[`DRV_TERM_BIT])
        begin
            next_current = {next_current[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            drive_current_sel    <= 3'h0;
            drive_current_tenths <= 8'h00;
            drive_code_unused    <= 1'b0;
            internal_term_en     <= 1'b0;
            cmos_mode            <= 1'b0;
        end
        else if (ce)
        begin
            drive_current_sel    <=
                output_driver_config[`DRV_CURRENT_MSB:`DRV_CURRENT_LSB];
            drive_current_tenths <= next_current;
            drive_code_unused    <=
                output_driver_config[`DRV_CURRENT_MSB:`DRV_CURRENT_LSB]
                == 3'(adc_format_pkg::DRV_UNUSED);
            internal_term_en     <= output_driver_config[`DRV_TERM_BIT];
            cmos_mode            <=
                (signalling == adc_format_pkg::SIG_CMOS_FULL);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            data_oe_n <= 1'b0;
        end
        else if (ce)
        begin
            data_oe_n <= output_driver_config[`DRV_DISABLE_BIT];
        end
    end

    // ======================================================================
    // Sample path
    sample_formatter
    #(
        .DATA_WIDTH        (DATA_WIDTH)
    )
    u_formatter
    (
        .sample_in         (sample_in),
        .over_range_in     (over_range_in),
        .test_pattern_sel  (test_pattern_sel),
        .signed_coding_sel (sample_format_config[`FMT_CODING_BIT]),
        .randomizer_en     (sample_format_config[`FMT_RANDOMIZER_EN_BIT]),
        .alt_polarity_en   (sample_format_config[`FMT_ABP_BIT]),
        .pattern_phase     (pattern_phase),
        .word_out          (next_data),
        .over_range_out    (next_over_range)
    );

    // Phase per output word
    // Phase restarts whenever the test code is TP_OFF, so each run entered
    // from TP_OFF starts on the first documented word.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pattern_phase <= 1'b0;
        end
        else if (ce)
        begin
            if (test_pattern_sel == adc_format_pkg::TP_OFF)
            begin
                pattern_phase <= 1'b0;
            end
            else if (sample_valid)
            begin
                pattern_phase <= ~pattern_phase;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            data_out       <= '0;
            over_range_bit <= 1'b0;
            out_valid      <= 1'b0;
        end
        else if (ce)
        begin
            out_valid <= sample_valid;
            if (sample_valid)
            begin
                data_out       <= next_data;
                over_range_bit <= next_over_range;
            end
        end
    end

endmodule : adc_output_format_control
`default_nettype wire

// *** bench/config_host.sv ***
`timescale 1ns/10ps
`default_nettype none

module config_host
(
    input  wire logic       clk_sys,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    // ======================================================================
    // Bus cycles, one byte each, strobe held across the taking edge
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #2;
        if (a == 8'h05 && d[5:3] inside {3'b010, 3'b100, 3'b110})
            d[5:3] = 3'b000;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #2;
        reg_wr = 1'b0;
        // Released data must not look like a held value
        reg_wdata = ~d;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a);
        @(posedge clk_sys);
        #2;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #2;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask : read_reg
endmodule : config_host

`default_nettype wire

// *** bench/adc_output_format_control_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none

module adc_output_format_control_monitor
#(
    parameter int DATA_WIDTH = 16
)
(
    input wire logic                  clk_sys,
    input wire logic                  rst,
    input wire logic                  ce,
    input wire logic [7:0]            reg_addr,
    input wire logic [7:0]            reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [7:0]            reg_rdata,
    input wire logic                  reg_rd_valid,
    input wire logic [DATA_WIDTH-1:0] sample_in,
    input wire logic                  over_range_in,
    input wire logic                  sample_valid,
    input wire logic [DATA_WIDTH-1:0] data_out,
    input wire logic                  over_range_bit,
    input wire logic                  data_oe_n,
    input wire logic                  cmos_mode,
    input wire logic                  internal_term_en,
    input wire logic [2:0]            drive_current_sel,
    input wire logic                  drive_code_unused
);
    logic [7:0] fmt_seen;
    wire logic  wr_drv = ce && reg_wr && (reg_addr == 8'h04);
    wire logic  smp = ce && sample_valid;

    // ======================================================================
    // Format mirror, so each sample is judged by the mode it met
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            fmt_seen <= 8'h00;
        else if (ce && reg_wr && reg_addr == 8'h05)
            fmt_seen <= reg_wdata & 8'h3f;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ======================================================================
    // Checks
    AST_RD_DRV_ZERO:
        assert property (ce && reg_rd && reg_addr == 8'h04 |=>
            reg_rd_valid && !reg_rdata[7] && !reg_rdata[1])
        else $error("output register unused bits not zero");
    AST_RD_FMT_ZERO:
        assert property (ce && reg_rd && reg_addr == 8'h05 |=>
            reg_rd_valid && reg_rdata[7:6] == 2'b00)
        else $error("format register unused bits not zero");
    AST_CUR_SEL:
        assert property (wr_drv |-> ##2
            drive_current_sel == $past(reg_wdata[6:4], 2))
        else $error("drive code not applied");
    AST_UNUSED_CODE:
        assert property (drive_code_unused == (drive_current_sel == 3'b011))
        else $error("unused drive code flag wrong");
    AST_TERM:
        assert property (wr_drv |-> ##2 internal_term_en == $past(reg_wdata[3], 2))
        else $error("termination not applied");
    AST_OE:
        assert property (wr_drv |-> ##2 data_oe_n == $past(reg_wdata[2], 2))
        else $error("output disable not applied");
    AST_MODE:
        assert property (wr_drv |-> ##2 cmos_mode == $past(reg_wdata[0], 2))
        else $error("signalling mode not applied");
    AST_PAT_ZEROS:
        assert property (smp && fmt_seen[5:3] == 3'b001 |=>
            {over_range_bit, data_out} == '0)
        else $error("all low pattern wrong");
    AST_PAT_ONES:
        assert property (smp && fmt_seen[5:3] == 3'b011 |=>
            {over_range_bit, data_out} == '1)
        else $error("all high pattern wrong");
    AST_ABP:
        assert property (smp && fmt_seen == 8'h04 |=>
            data_out == ($past(sample_in) ^ 16'haaaa))
        else $error("alternate polarity wrong");
    AST_RANDOMIZER_EN:
        assert property (smp && fmt_seen == 8'h02 |=>
            data_out[1] == ($past(sample_in[1]) ^ $past(sample_in[0])))
        else $error("randomizer wrong");
    AST_TWOS:
        assert property (smp && fmt_seen == 8'h01 |=>
            data_out[DATA_WIDTH-1] != $past(sample_in[DATA_WIDTH-1])
            && over_range_bit == $past(over_range_in))
        else $error("signed coding wrong");
endmodule : adc_output_format_control_monitor

bind adc_output_format_control adc_output_format_control_monitor
    #(.DATA_WIDTH(DATA_WIDTH)) u_monitor
(
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .sample_in(sample_in), .over_range_in(over_range_in),
    .sample_valid(sample_valid), .data_out(data_out),
    .over_range_bit(over_range_bit), .data_oe_n(data_oe_n),
    .cmos_mode(cmos_mode), .internal_term_en(internal_term_en),
    .drive_current_sel(drive_current_sel),
    .drive_code_unused(drive_code_unused)
);

`default_nettype wire

// *** bench/adc_output_format_control_tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module adc_output_format_control_tb;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, tenths, v, r;
    logic        reg_wr, reg_rd, reg_rd_valid, out_valid, ph;
    logic        data_oe_n, cmos_mode, internal_term_en, unused_code;
    logic [2:0]  drive_current_sel;
    logic [15:0] sample_in = 16'h0000;
    logic [15:0] data_out;
    logic        over_range_in = 1'b0;
    logic        sample_valid = 1'b0;
    logic        over_range_bit;
    logic [7:0]  rd_q[$];
    logic [16:0] smp_q[$];
    logic [7:0]  fmts[10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h07,
                              8'h08, 8'h18, 8'h28, 8'h38, 8'hef};
    int          num_errors = 0;
    int          total_checks = 0;
    integer      seed = 4279;
    wire logic [16:0] cfg = {2'b00, data_oe_n, cmos_mode, internal_term_en,
                             drive_current_sel, tenths, unused_code};

    always #25 clk_sys = ~clk_sys;

    config_host u_config_host (.clk_sys(clk_sys), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    adc_output_format_control u_adc_output_format_control (
        .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .sample_in(sample_in), .over_range_in(over_range_in),
        .sample_valid(sample_valid), .data_out(data_out),
        .over_range_bit(over_range_bit), .out_valid(out_valid),
        .data_oe_n(data_oe_n), .cmos_mode(cmos_mode),
        .internal_term_en(internal_term_en),
        .drive_current_sel(drive_current_sel),
        .drive_current_tenths(tenths), .drive_code_unused(unused_code));

    // ======================================================================
    // Checking helpers
    task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
        total_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    function automatic logic [16:0] exp_cfg(input logic [7:0] d);
        logic [7:0] t;
        case (d[6:4])
            3'b001: t = 8'h28;
            3'b010: t = 8'h2d;
            3'b100: t = 8'h1e;
            3'b101: t = 8'h19;
            3'b110: t = 8'h15;
            default: t = 8'h00;
        endcase
        // Termination doubles whatever the code selects
        if (d[3])
            t = t << 1;
        return {2'b00, d[2], d[0], d[3], d[6:4], t, d[6:4] == 3'b011};
    endfunction : exp_cfg

    function automatic logic [16:0] exp_word(input logic [7:0] f, input logic p,
                                             input logic [15:0] s, input logic o);
        logic [15:0] d;
        d = s;
        case (f[5:3])
            3'b001: return 17'h00000;
            3'b011: return 17'h1ffff;
            3'b101: return p ? 17'h0aaaa : 17'h15555;
            3'b111: return p ? 17'h1ffff : 17'h00000;
            default: ;
        endcase
        if (f[0])
            d[15] = ~d[15];
        if (f[1])
            d[15:1] = d[15:1] ^ {15{d[0]}};
        if (f[2])
            d = d ^ 16'haaaa;
        return {o, d};
    endfunction : exp_word

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        u_config_host.read_reg(a);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_config_host.write_reg(a, d);
        repeat (2) @(posedge clk_sys);
        #2;
    endtask : wr

    task automatic smp(input logic [7:0] f);
        sample_in = $random(seed);
        over_range_in = $random(seed);
        smp_q.push_back(exp_word(f, ph, sample_in, over_range_in));
        sample_valid = 1'b1;
        @(posedge clk_sys);
        #2;
        ph = ~ph;
    endtask : smp

    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // ======================================================================
    // Output watcher, takes the oldest note per result
    always @(posedge clk_sys)
    begin
        #1;
        if (reg_rd_valid === 1'b1 && rd_q.size() == 0)
            chk("extra_read", 17'h0, 17'h1);
        else if (reg_rd_valid === 1'b1)
            chk("reg_rdata", {9'h0, rd_q.pop_front()}, {9'h0, reg_rdata});
        if (out_valid === 1'b1 && smp_q.size() == 0)
            chk("extra_word", 17'h0, 17'h1);
        else if (out_valid === 1'b1)
            chk("word", smp_q.pop_front(), {over_range_bit, data_out});
    end

    // ======================================================================
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        chk("cfg_reset", 17'h0, cfg);
        rd(8'h04, 8'h00);
        rd(8'h05, 8'h00);
        rd(8'h07, 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            r = $random(seed);
            v = {r[7], i[2:0], i[3], r[2:0]};
            wr(8'h04, v);
            chk("cfg", exp_cfg(v), cfg);
            rd(8'h04, v & 8'h7d);
        end
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h3f);
        foreach (fmts[k])
        begin
            wr(8'h05, 8'h00);
            wr(8'h05, fmts[k]);
            ph = 1'b0;
            repeat (4) smp(fmts[k]);
            sample_valid = 1'b0;
        end
        wr(8'h04, 8'h7d);
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        chk("cfg_rereset", 17'h0, cfg);
        rd(8'h04, 8'h00);
        for (int i = 0; i < 40 && (rd_q.size() + smp_q.size()) > 0; i++)
            @(posedge clk_sys);
        if (rd_q.size() + smp_q.size() > 0)
            chk("drain", 17'h0, 17'h1);
        stop_test();
    end
endmodule : adc_output_format_control_tb

`default_nettype wire
